// [core/pma_pkg.sv]
// How it works
// - Motion evaluation always uses the band-pass output, whatever readout source.
// - Detection runs only in alarm mode; host must select that mode.
// - On motion the host line is driven high and held until cleared.
// - After a clear, detection is suppressed for the programmed blind interval.
// - Samples are requested no faster than every 2.0 ms.
// - Results are 14 bit; usable range 511 to 2^14-511 counts.
// - Internal sequencing runs on a 32 kHz tick from a divider.
// - Configuration is volatile; host writes a full word after power-up.
// - Configuration is written only through the serial configuration input.
// - Host line is alarm output in alarm mode, data channel in forced and event modes.
// - Converter input selects element or temperature sensor per source.
// - Mode field: 0 forced, 1 event-driven, 2 alarm, 3 reserved.
// - Blind interval is 0.5 s plus field times 0.5 s, from host fall.
// - Count threshold pulses in a 2 to 8 s window; alarm at 1-4.
// - 25 serial bits, rising edge then value; latch after 650 us low.
package pma_pkg;

	// Clock and oscillator rates
	localparam int CLK_HZ = 200_000_000;
	localparam int OSC_HZ = 32_000;
	localparam int TICK_DIV = CLK_HZ / OSC_HZ;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;

	// Sampling interval, least and event-mode most
	localparam int SAMPLE_US = 2000;
	localparam int SAMPLE_MAX_US = 12500;
	localparam int SAMPLE_TICKS = (SAMPLE_US * OSC_HZ + 999_999) / 1_000_000;

	// Host clear pulse and serial configuration timing
	localparam int CLEAR_US = 160;
	localparam int CLEAR_CYC = CLEAR_US * CYC_PER_US;
	localparam int CFG_HOLD_US = 80;
	localparam int CFG_SAMPLE_CYC = CFG_HOLD_US * CYC_PER_US / 2;
	localparam int CFG_LOAD_US = 650;
	localparam int CFG_LOAD_CYC = CFG_LOAD_US * CYC_PER_US + 1;
	localparam int CFG_TMR_W = 18;

	// Blind and window steps in oscillator ticks
	localparam int BLIND_STEP_MS = 500;
	localparam int BLIND_STEP_TICKS = BLIND_STEP_MS * OSC_HZ / 1000;
	localparam int WINDOW_STEP_MS = 2000;
	localparam int WINDOW_STEP_TICKS = WINDOW_STEP_MS * OSC_HZ / 1000;
	localparam int TICK_CNT_W = 18;

	// Converter data
	localparam int ADC_W = 14;
	localparam logic [13:0] RANGE_LO = 14'h1FF;
	localparam logic [13:0] RANGE_HI = 14'h3E01;

	// Configuration word layout
	localparam int CFG_BITS = 25;
	localparam logic [24:0] CFG_RESET = 25'h0000000;
	localparam int THR_LSB = 17;
	localparam int BLIND_LSB = 13;
	localparam int PULSE_LSB = 11;
	localparam int WIN_LSB = 9;
	localparam int MODE_LSB = 7;
	localparam int SRC_LSB = 5;
	localparam int CNT_MODE_BIT = 0;

	typedef enum logic [1:0] {
		MODE_FORCED = 2'h0,
		MODE_EVENT = 2'h1,
		MODE_ALARM = 2'h2,
		MODE_RSVD = 2'h3
	} pma_mode_t;

	localparam logic [1:0] SRC_BPF = 2'h0;
	localparam logic [1:0] SRC_LPF = 2'h1;
	localparam logic [1:0] SRC_TEMP = 2'h3;

	// Alarm line states, Gray along armed-alarm-clear-blind
	typedef enum logic [1:0] {
		ST_ARMED = 2'h0,
		ST_ALARM = 2'h1,
		ST_CLEAR = 2'h3,
		ST_BLIND = 2'h2
	} pma_alarm_t;

	// Register port map
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h1;
	localparam logic [3:0] REG_CONFIG = 4'h2;
	localparam logic [3:0] REG_STATE = 4'h3;
	localparam int STAT_W = 3;
	localparam int STAT_ALARM = 0;
	localparam int STAT_CFG = 1;
	localparam int STAT_OOR = 2;

endpackage : pma_pkg

// [core/pma_sync.sv]
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves once stages two and three agree
module pma_sync (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pin,
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_d;

	// Only the second stage ever reads the first
	always_comb begin
		level_d = (s2_q == s3_q) ? s3_q : level;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level <= level_d;
		end
	end
endmodule : pma_sync

// [core/pma_pulse_det.sv]
`timescale 1ns/1ps
// Threshold pulse counter over a window on band-pass samples
module pma_pulse_det
	import pma_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic tick,
	input wire logic sample_valid,
	input wire logic [13:0] band_pass_output,
	input wire logic [7:0] threshold,
	input wire logic [1:0] pulse_field,
	input wire logic [1:0] window_field,
	input wire logic count_any,
	output logic hit_q
);
	localparam logic [17:0] WIN_STEP = 18'(WINDOW_STEP_TICKS);

	logic above_q, above_d;
	logic sign_q, sign_d;
	logic [2:0] cnt_q, cnt_d;
	logic [17:0] win_q, win_d;
	logic hit_d;
	logic [14:0] mag;
	logic over;
	logic fresh;

	// Magnitude in 15 bits so the most negative value cannot wrap
	always_comb begin
		mag = band_pass_output[13] ? 15'(-{band_pass_output[13], band_pass_output})
			: {1'b0, band_pass_output};
		over = mag > {7'h00, threshold};
		fresh = sample_valid && over && !above_q
			&& (count_any || cnt_q == 3'h0 || band_pass_output[13] != sign_q);
	end

	// Window opens on the first pulse and drops the count when it runs out
	always_comb begin
		above_d = above_q;
		sign_d = sign_q;
		cnt_d = cnt_q;
		win_d = win_q;
		hit_d = 1'b0;
		if (!enable) begin
			above_d = 1'b0;
			cnt_d = 3'h0;
			win_d = 18'h00000;
		end else begin
			if (sample_valid) begin
				above_d = over;
			end
			if (tick && cnt_q != 3'h0) begin
				if (win_q <= 18'h00001) begin
					cnt_d = 3'h0;
				end else begin
					win_d = win_q - 18'h00001;
				end
			end
			if (fresh) begin
				sign_d = band_pass_output[13];
				if (cnt_q == 3'h0 || cnt_d == 3'h0) begin
					win_d = 18'({16'h0000, window_field} + 18'h00001) * WIN_STEP;
				end
				if ((cnt_d + 3'h1) == ({1'b0, pulse_field} + 3'h1)) begin
					hit_d = 1'b1;
					cnt_d = 3'h0;
				end else begin
					cnt_d = cnt_d + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			above_q <= 1'b0;
			sign_q <= 1'b0;
			cnt_q <= 3'h0;
			win_q <= 18'h00000;
			hit_q <= 1'b0;
		end else begin
			above_q <= above_d;
			sign_q <= sign_d;
			cnt_q <= cnt_d;
			win_q <= win_d;
			hit_q <= hit_d;
		end
	end
endmodule : pma_pulse_det

// [core/pma_motion_alarm.sv]
`timescale 1ns/1ps
// Digital back end: configuration receiver, sampling, motion alarm on the host line
module pma_motion_alarm
	import pma_pkg::*;
#(
	parameter int TICK_DIV_P = TICK_DIV,
	parameter int CLEAR_CYC_P = CLEAR_CYC,
	parameter int CFG_SAMPLE_CYC_P = CFG_SAMPLE_CYC,
	parameter int CFG_LOAD_CYC_P = CFG_LOAD_CYC,
	parameter int BLIND_STEP_P = BLIND_STEP_TICKS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic config_serial_input,
	input wire logic link_in,
	output logic link_out,
	output logic link_oe_n,
	output logic converter_input_selector,
	output logic sample_req,
	input wire logic sample_valid,
	input wire logic [13:0] element_data,
	input wire logic [13:0] temp_data,
	input wire logic [13:0] band_pass_output,
	output logic [13:0] readout_data,
	output logic readout_active,
	output logic out_of_range,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	// Clear count starts a cycle after the synced fall, so end one short:
	// a host low of exactly the minimum still clears
	localparam logic [15:0] DIV_LAST = 16'(TICK_DIV_P - 1);
	localparam logic [17:0] CLEAR_LAST = 18'(CLEAR_CYC_P - 2);
	localparam logic [17:0] CFG_SMP = 18'(CFG_SAMPLE_CYC_P);
	localparam logic [17:0] CFG_LOAD = 18'(CFG_LOAD_CYC_P);
	localparam logic [17:0] BLIND_STEP = 18'(BLIND_STEP_P);
	localparam logic [6:0] SAMPLE_LAST = 7'(SAMPLE_TICKS - 1);
	localparam logic [4:0] CFG_FULL = 5'(CFG_BITS);

	logic ser;
	logic link_s;
	logic hit;

	pma_sync u_ser_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin(config_serial_input),
		.level(ser)
	);

	pma_sync u_link_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin(link_in),
		.level(link_s)
	);

	// ---- Oscillator tick and sample pacing ----
	logic [15:0] div_q, div_d;
	logic tick_q, tick_d;
	logic [6:0] smp_q, smp_d;
	logic sample_req_d;

	// Sample period is fixed at the least interval, well inside the event-mode bound
	always_comb begin
		tick_d = (div_q == DIV_LAST);
		div_d = tick_d ? 16'h0000 : div_q + 16'h0001;
		smp_d = smp_q;
		sample_req_d = 1'b0;
		if (tick_q) begin
			if (smp_q == SAMPLE_LAST) begin
				smp_d = 7'h00;
				sample_req_d = 1'b1;
			end else begin
				smp_d = smp_q + 7'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
			smp_q <= 7'h00;
			sample_req <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
			smp_q <= smp_d;
			sample_req <= sample_req_d;
		end
	end

	// ---- Serial configuration receiver ----
	logic ser_prev_q;
	logic [24:0] shift_q, shift_d;
	logic [4:0] bits_q, bits_d;
	logic [17:0] ctmr_q, ctmr_d;
	logic wait_q, wait_d;
	logic [24:0] cfg_q, cfg_d;
	logic cfg_ev;

	// Only this path writes the configuration; the register port cannot
	always_comb begin
		shift_d = shift_q;
		bits_d = bits_q;
		wait_d = wait_q;
		cfg_d = cfg_q;
		cfg_ev = 1'b0;
		ctmr_d = (ctmr_q == CFG_LOAD) ? ctmr_q : ctmr_q + 18'h00001;
		if (ser && !ser_prev_q && !wait_q) begin
			wait_d = 1'b1;
			ctmr_d = 18'h00000;
		end else if (wait_q) begin
			if (ctmr_q == CFG_SMP) begin
				shift_d = {shift_q[23:0], ser};
				bits_d = (bits_q == CFG_FULL) ? bits_q : bits_q + 5'h01;
				wait_d = 1'b0;
				ctmr_d = 18'h00000;
			end
		end else if (ser) begin
			ctmr_d = 18'h00000;
		end else if (ctmr_q == CFG_LOAD - 18'h00001) begin
			if (bits_q == CFG_FULL) begin
				cfg_d = shift_q;
				cfg_ev = 1'b1;
			end
			bits_d = 5'h00;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ser_prev_q <= 1'b0;
			shift_q <= 25'h0000000;
			bits_q <= 5'h00;
			ctmr_q <= 18'h00000;
			wait_q <= 1'b0;
			cfg_q <= CFG_RESET;
		end else begin
			ser_prev_q <= ser;
			shift_q <= shift_d;
			bits_q <= bits_d;
			ctmr_q <= ctmr_d;
			wait_q <= wait_d;
			cfg_q <= cfg_d;
		end
	end

	// Configuration fields
	pma_mode_t mode;
	logic [1:0] src;
	logic [3:0] blind_field;
	assign mode = pma_mode_t'(cfg_q[MODE_LSB +: 2]);
	assign src = cfg_q[SRC_LSB +: 2];
	assign blind_field = cfg_q[BLIND_LSB +: 4];

	// ---- Alarm line state machine ----
	pma_alarm_t st_q, st_d;
	logic link_prev_q;
	logic [17:0] clr_q, clr_d;
	logic [17:0] blind_q, blind_d;
	logic [17:0] blind_len;
	logic out_d, oe_n_d;
	logic alarm_ev;

	// Released unless alarm mode, and in alarm mode while the clear runs; readout framing sits outside this block
	always_comb begin
		st_d = st_q;
		clr_d = clr_q;
		blind_d = (tick_q && blind_q != 18'h3FFFF) ? blind_q + 18'h00001 : blind_q;
		blind_len = 18'({14'h0000, blind_field} + 18'h00001) * BLIND_STEP;
		alarm_ev = 1'b0;
		if (mode != MODE_ALARM) begin
			st_d = ST_ARMED;
		end else begin
			unique case (st_q)
				ST_ARMED: begin
					if (hit) begin
						st_d = ST_ALARM;
						alarm_ev = 1'b1;
					end
				end
				ST_ALARM: begin
					if (link_prev_q && !link_s) begin
						st_d = ST_CLEAR;
						clr_d = 18'h00000;
						blind_d = 18'h00000;
					end
				end
				ST_CLEAR: begin
					clr_d = clr_q + 18'h00001;
					if (link_s) begin
						st_d = ST_ALARM;
					end else if (clr_q == CLEAR_LAST) begin
						st_d = ST_BLIND;
					end
				end
				ST_BLIND: begin
					if (blind_q >= blind_len) begin
						st_d = ST_ARMED;
					end
				end
			endcase
		end
		oe_n_d = (mode != MODE_ALARM) || (st_d == ST_CLEAR);
		out_d = (st_d == ST_ALARM);
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= ST_ARMED;
			link_prev_q <= 1'b0;
			clr_q <= 18'h00000;
			blind_q <= 18'h00000;
			link_out <= 1'b0;
			link_oe_n <= 1'b1;
		end else begin
			st_q <= st_d;
			link_prev_q <= link_s;
			clr_q <= clr_d;
			blind_q <= blind_d;
			link_out <= out_d;
			link_oe_n <= oe_n_d;
		end
	end

	// Detection sees only the band-pass stream, and only while armed
	pma_pulse_det u_det (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.enable(mode == MODE_ALARM && st_q == ST_ARMED),
		.tick(tick_q),
		.sample_valid(sample_valid),
		.band_pass_output(band_pass_output),
		.threshold(cfg_q[THR_LSB +: 8]),
		.pulse_field(cfg_q[PULSE_LSB +: 2]),
		.window_field(cfg_q[WIN_LSB +: 2]),
		.count_any(cfg_q[CNT_MODE_BIT]),
		.hit_q(hit)
	);

	// ---- Readout path ----
	logic [13:0] rdat_d;
	logic oor_d, oor_ev;
	logic sel_d;

	// Range check on the raw element value, held until the next sample
	always_comb begin
		sel_d = (src == SRC_TEMP);
		rdat_d = readout_data;
		oor_d = out_of_range;
		oor_ev = 1'b0;
		if (sample_valid) begin
			unique case (src)
				SRC_BPF: rdat_d = band_pass_output;
				SRC_LPF: rdat_d = element_data;
				SRC_TEMP: rdat_d = temp_data;
				default: rdat_d = 14'h0000;
			endcase
			oor_d = (element_data < RANGE_LO) || (element_data > RANGE_HI);
			oor_ev = oor_d;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			converter_input_selector <= 1'b0;
			readout_data <= 14'h0000;
			readout_active <= 1'b0;
			out_of_range <= 1'b0;
		end else begin
			converter_input_selector <= sel_d;
			readout_data <= rdat_d;
			readout_active <= (mode == MODE_FORCED) || (mode == MODE_EVENT);
			out_of_range <= oor_d;
		end
	end

	// ---- Register port: status, mask, config view, state ----
	logic [STAT_W-1:0] stat_q, stat_d;
	logic [STAT_W-1:0] mask_q, mask_d;
	logic [31:0] rdata_d;
	logic irq_d;

	// Set wins over a same-cycle write-one clear
	always_comb begin
		stat_d = stat_q;
		mask_d = mask_q;
		if (reg_wr && reg_addr == REG_STATUS) begin
			stat_d = stat_q & ~reg_wdata[STAT_W-1:0];
		end
		if (reg_wr && reg_addr == REG_MASK) begin
			mask_d = reg_wdata[STAT_W-1:0];
		end
		stat_d[STAT_ALARM] = stat_d[STAT_ALARM] | alarm_ev;
		stat_d[STAT_CFG] = stat_d[STAT_CFG] | cfg_ev;
		stat_d[STAT_OOR] = stat_d[STAT_OOR] | oor_ev;
		irq_d = |(stat_d & mask_d);
		rdata_d = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_STATUS: rdata_d = {29'h00000000, stat_q};
				REG_MASK: rdata_d = {29'h00000000, mask_q};
				REG_CONFIG: rdata_d = {7'h00, cfg_q};
				REG_STATE: rdata_d = {29'h00000000, link_s, st_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_q <= '0;
			mask_q <= '0;
			reg_rdata <= 32'h00000000;
			irq <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			reg_rdata <= rdata_d;
			irq <= irq_d;
		end
	end

endmodule : pma_motion_alarm

// [tb/pma_motion_alarm_asserts.sv]
`timescale 1ns/1ps
// Port-level checks of the motion alarm block
module pma_motion_alarm_asserts
	import pma_pkg::*;
#(
	parameter int TICK_DIV_P = TICK_DIV
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_in,
	input wire logic link_out,
	input wire logic link_oe_n,
	input wire logic sample_req,
	input wire logic sample_valid,
	input wire logic [13:0] element_data,
	input wire logic [13:0] temp_data,
	input wire logic converter_input_selector,
	input wire logic [13:0] readout_data,
	input wire logic readout_active,
	input wire logic out_of_range,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	localparam int GAP = 64 * TICK_DIV_P;
	logic [19:0] gap_q;
	logic [19:0] gap_d;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// Cycles since the last sample request, saturating so it never wraps
	always_comb begin
		gap_d = sample_req ? 20'h00000 : gap_q + ((&gap_q) ? 20'h00000 : 20'h00001);
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gap_q <= 20'h00000;
		end else begin
			gap_q <= gap_d;
		end
	end
	chk_alarm_hold: assert property (
		link_in [*5] ##0 (link_out && !link_oe_n) |=> link_out && !link_oe_n)
		else $error("Alarm drive dropped while line high");
	chk_clear_release: assert property (
		link_out && !link_oe_n && $fell(link_in) |-> ##[1:6] link_oe_n)
		else $error("Line not released after host pull");
	chk_readout_free: assert property (
		readout_active && $past(readout_active) |-> link_oe_n)
		else $error("Line driven in readout mode");
	chk_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("Read data outside read answer");
	chk_unmapped_zero: assert property (
		reg_rd && reg_addr > 4'h3 |=> reg_rdata == 32'h0)
		else $error("Unmapped read not zero");
	chk_req_gap: assert property (
		sample_req |-> gap_q >= GAP - TICK_DIV_P)
		else $error("Sample requests too close");
	chk_req_late: assert property (
		gap_q <= GAP + TICK_DIV_P)
		else $error("Sample request overdue");
	chk_oor_set: assert property (
		sample_valid && (element_data < RANGE_LO || element_data > RANGE_HI) |=> out_of_range)
		else $error("Out of range not flagged");
	chk_oor_clear: assert property (
		sample_valid && element_data >= RANGE_LO && element_data <= RANGE_HI |=> !out_of_range)
		else $error("In range sample flagged");
	chk_temp_capture: assert property (
		sample_valid && converter_input_selector |=> readout_data == $past(temp_data))
		else $error("Temperature value not captured");
	// Main scenarios reached
	cov_alarm: cover property (link_out && !link_oe_n);
	cov_release: cover property ($past(link_out) && $rose(link_oe_n));
	cov_oor: cover property (sample_valid ##1 out_of_range);
endmodule : pma_motion_alarm_asserts

bind pma_motion_alarm pma_motion_alarm_asserts #(.TICK_DIV_P(TICK_DIV_P)) chk_u (
	.sys_clk, .sys_rst, .link_in, .link_out, .link_oe_n, .sample_req, .sample_valid,
	.element_data, .temp_data, .converter_input_selector, .readout_data,
	.readout_active, .out_of_range, .reg_addr, .reg_rd, .reg_rdata
);

// [tb/pma_host_model.sv]
`timescale 1ns/1ps
// Host side of the alarm line and the serial configuration input
module pma_host_model (
	input wire logic sys_clk,
	input wire logic link_out,
	input wire logic link_oe_n,
	output logic config_serial_input,
	output logic link_in
);
	logic pull_q = 1'b0;
	logic high_q = 1'b0;
	logic float_q = 1'b0;
	logic line_prev_q = 1'b0;
	int rises = 0;
	// No pull resistor: a released line shows the inverse of its last driven level
	always @(posedge sys_clk) begin
		if (pull_q || high_q || !link_oe_n) begin
			float_q <= ~link_in;
		end
		line_prev_q <= link_in;
		// Host wakes on a rising edge only, not on the level
		if (link_in && !line_prev_q) begin
			rises <= rises + 1;
		end
	end
	// Host drive wins; a clear is a deliberate fight with the alarm drive
	assign link_in = pull_q ? 1'b0 : high_q ? 1'b1 : !link_oe_n ? link_out : float_q;
	initial begin
		config_serial_input = 1'b0;
	end
	// Full word, first bit first, line kept low meanwhile
	task automatic send_cfg(input logic [24:0] w);
		@(posedge sys_clk);
		pull_q <= 1'b1;
		for (int i = 24; i >= 0; i--) begin
			config_serial_input <= 1'b0;
			repeat (2) @(posedge sys_clk);
			config_serial_input <= 1'b1;
			repeat (2) @(posedge sys_clk);
			config_serial_input <= w[i];
			repeat (20) @(posedge sys_clk);
		end
		config_serial_input <= 1'b0;
		repeat (60) @(posedge sys_clk);
		pull_q <= 1'b0;
	endtask : send_cfg
	// Low pulse; an aborted one drives high briefly before letting go
	task automatic clear(input int n, input logic abort);
		@(posedge sys_clk);
		pull_q <= 1'b1;
		repeat (n) @(posedge sys_clk);
		pull_q <= 1'b0;
		high_q <= abort;
		repeat (6) @(posedge sys_clk);
		high_q <= 1'b0;
	endtask : clear
endmodule : pma_host_model

// [tb/tb.sv]
`timescale 1ns/1ps
// Bench: front end and register master, host model on the line
module tb
	import pma_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic config_serial_input, link_in, link_out, link_oe_n, converter_input_selector;
	logic sample_req, sample_valid, readout_active, out_of_range, reg_wr, reg_rd, irq;
	logic [13:0] element_data, temp_data, band_pass_output, readout_data, vb, ve, vt;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [24:0] w;
	logic [1:0] srcs [3] = '{SRC_BPF, SRC_LPF, SRC_TEMP};
	logic [13:0] edge_e [4] = '{14'h1FE, 14'h1FF, 14'h3E01, 14'h3E02};
	integer seed, fails, checks_done;
	int r0;
	always #2.5 sys_clk = ~sys_clk;
	// Short counts keep the run small
	pma_motion_alarm #(.TICK_DIV_P(4), .CLEAR_CYC_P(20), .CFG_SAMPLE_CYC_P(10),
		.CFG_LOAD_CYC_P(40), .BLIND_STEP_P(3)) dut_u (
		.sys_clk, .sys_rst, .config_serial_input, .link_in, .link_out, .link_oe_n,
		.converter_input_selector, .sample_req, .sample_valid, .element_data, .temp_data,
		.band_pass_output, .readout_data, .readout_active, .out_of_range, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
	);
	pma_host_model host_u (.sys_clk, .link_out, .link_oe_n, .config_serial_input, .link_in);
	function automatic logic [24:0] cfgw(input logic [7:0] th, input logic [3:0] bl,
		input logic [1:0] pc, input logic [1:0] md, input logic [1:0] sr, input logic cm);
		return {th, bl, pc, 2'h0, md, sr, 2'h2, 1'b0, 1'b0, cm};
	endfunction : cfgw
	function automatic logic [13:0] exp_ro(input logic [1:0] s, input logic [13:0] b,
		input logic [13:0] e, input logic [13:0] t);
		return (s == SRC_TEMP) ? t : (s == SRC_LPF) ? e : b;
	endfunction : exp_ro
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_n
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask : rd
	task automatic smp(input logic [13:0] b, input logic [13:0] e, input logic [13:0] t);
		@(posedge sys_clk);
		band_pass_output <= b;
		element_data <= e;
		temp_data <= t;
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
	endtask : smp
	task automatic close_out;
		$display("Checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// Watchdog, well beyond the expected run
	initial begin
		#200000;
		fails++;
		close_out();
	end
	// Main sequence
	initial begin
		seed = 32'h1571;
		fails = 0;
		checks_done = 0;
		{sample_valid, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{element_data, temp_data, band_pass_output} = '0;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wait_n(1);
		chk(32'({link_oe_n, link_out, irq}), 32'h4);
		rd(REG_CONFIG);
		chk(rv, 32'h0);
		wr(REG_CONFIG, 32'hFFFFFFFF);
		rd(REG_CONFIG);
		chk(rv, 32'h0);
		rd(4'hF);
		chk(rv, 32'h0);
		wr(REG_MASK, 32'h1);
		rd(REG_MASK);
		chk(rv, 32'h1);
		// Forced, event and alarm modes; only the alarm one raises the line, source stays temperature there
		for (int m = 0; m < 3; m++) begin
			w = cfgw(8'h40, 4'hF, 2'h0, 2'(m), (m == 2) ? SRC_TEMP : SRC_BPF, 1'b1);
			host_u.send_cfg(w);
			rd(REG_CONFIG);
			chk(rv, {7'h0, w});
			chk(32'({readout_active, converter_input_selector}), (m == 2) ? 32'h1 : 32'h2);
			smp(14'h0, 14'h1F40, 14'h0);
			smp(14'h0100, 14'h1F40, 14'h0);
			wait_n(4);
			chk(32'({link_oe_n, link_out & (m == 2)}), (m == 2) ? 32'h1 : 32'h2);
		end
		wait_n(20);
		chk(32'({link_oe_n, link_out, irq}), 32'h3);
		wr(REG_MASK, 32'h0);
		wait_n(2);
		chk(32'(irq), 32'h0);
		wr(REG_MASK, 32'h1);
		rd(REG_STATUS);
		chk(rv, 32'h3);
		wr(REG_STATUS, 32'h1);
		rd(REG_STATUS);
		chk(32'({rv[1:0], irq, link_out}), 32'h9);
		// Too short a clear: alarm comes back
		host_u.clear(8, 1'b1);
		wait_n(6);
		chk(32'({link_oe_n, link_out}), 32'h1);
		fork
			host_u.clear(30, 1'b0);
			begin
				wait_n(10);
				chk(32'(link_oe_n), 32'h1);
			end
		join
		// Blind for 192 cycles from the fall: motion ignored, then armed again
		smp(14'h0, 14'h1F40, 14'h0);
		smp(14'h3F00, 14'h1F40, 14'h0);
		wait_n(4);
		chk(32'({link_oe_n, link_out}), 32'h0);
		rd(REG_STATE);
		chk(32'(rv[1:0]), 32'(ST_BLIND));
		wait_n(127);
		rd(REG_STATE);
		chk(32'(rv[1:0]), 32'(ST_BLIND));
		wait_n(34);
		rd(REG_STATE);
		chk(32'(rv[1:0]), 32'(ST_ARMED));
		// Two pulses with sign change required
		host_u.send_cfg(cfgw(8'h40, 4'h0, 2'h1, MODE_ALARM, SRC_BPF, 1'b0));
		r0 = host_u.rises;
		for (int k = 0; k < 3; k++) begin
			smp(14'h0, 14'h1F40, 14'h0);
			smp((k == 2) ? 14'h3F00 : 14'h0100, 14'h1F40, 14'h0);
			wait_n(4);
			chk(32'(link_out), (k == 2) ? 32'h1 : 32'h0);
		end
		// Exactly one wake-up edge for the one alarm
		chk(32'(host_u.rises - r0), 32'h1);
		// Readout of each source with random values
		for (int i = 0; i < 3; i++) begin
			host_u.send_cfg(cfgw(8'h40, 4'h0, 2'h0, MODE_FORCED, srcs[i], 1'b1));
			for (int k = 0; k < 4; k++) begin
				vb = 14'($random(seed));
				ve = 14'($random(seed));
				vt = 14'($random(seed));
				smp(vb, ve, vt);
				wait_n(1);
				chk(32'(readout_data), 32'(exp_ro(srcs[i], vb, ve, vt)));
			end
		end
		// Range edges just inside and outside
		for (int k = 0; k < 4; k++) begin
			smp(14'h0, edge_e[k], 14'h0);
			wait_n(1);
			chk(32'(out_of_range), 32'(edge_e[k] < RANGE_LO || edge_e[k] > RANGE_HI));
		end
		rd(REG_STATUS);
		chk(32'(rv[STAT_OOR]), 32'h1);
		close_out();
	end
endmodule : tb
